// [include/tmr_cfg.svh]
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// register byte offsets
`define TMR_OFS_CTRL_A 8'h00
`define TMR_OFS_CNT_L 8'h04
`define TMR_OFS_CNT_H 8'h08
`define TMR_OFS_CMP_A 8'h0C
`define TMR_OFS_CMP_B 8'h10
`define TMR_OFS_MASK 8'h14
`define TMR_OFS_FLAGS 8'h18

// flag and mask bit positions
`define TMR_FLG_OVF 0
`define TMR_FLG_CMPA 1
`define TMR_FLG_CMPB 2
`define TMR_FLG_CAP 3
`define TMR_NUM_FLAGS 4

// reset values
`define TMR_RST_CTRL 9'h000
`define TMR_RST_BYTE 8'h00
`define TMR_RST_FLAGS 4'h0

// count limits
`define TMR_BOTTOM 8'h00
`define TMR_MAX8 8'hFF

// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

// prescaler width, noise canceler sample count
`define TMR_PRE_W 10
`define TMR_NC_SAMPLES 4

`endif

// [include/tmr_pkg.sv]
package tmr_pkg;

  typedef struct packed {
    logic cap_src_cmp;
    logic cap_en;
    logic wide;
    logic edge_rise;
    logic noise_en;
    logic ctc;
    logic [2:0] clk_sel;
  } tmr_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
  } tmr_bus_req_t;

endpackage

// [hdl/tmr_timer.sv]
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
// Summary of operation
// - counter low byte, both compares are 8-bit
// - 16-bit mode adds counter high byte
// - 16-bit compare: A low, B high
// - flags in shared register, individually masked
// - bottom is 0x00, 8-bit max 0xFF
// - top is 0xFF (0xFFFF in 16-bit mode) or compare A
// - three-bit clock select, zero stops counting
// - increment per tick, wrap after top
// - clear-on-match bit picks wrap point in 8-bit mode without capture
// - counter readable and writable at any time
// - counter write beats count or clear
// - overflow flag set at maximum, may interrupt
// - capture from pin or comparator, time-stamped
// - compare A is capture reg, B high
// - 8-bit capture keeps B; 16-bit none
// - selected edge copies counter into capture
// - capture flag set same cycle as copy
// - capture flag interrupts, clears on ack/one
// - capture pin sampled like count pin
// - filter output changes after four equal samples
// - filter enable adds four cycles delay
// - filter runs on system clock
module tmr_timer
  import tmr_pkg::*;
#(
  parameter int PRE_W = `TMR_PRE_W,
  parameter int NC_SAMPLES = `TMR_NC_SAMPLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic external_count_pin,
  input wire logic [3:0] irq_ack,
  output logic [3:0] irq_req
);

  tmr_ctrl_t ctrl;
  tmr_bus_req_t req;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] compare_reg_a;
  logic [7:0] compare_reg_b;
  logic [3:0] timer_mask_register;
  logic [3:0] timer_flag_register;
  logic [3:0] next_flags;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [PRE_W-1:0] pre_cnt;
  logic ext_meta, ext_sync, ext_prev;
  logic cap_meta, cap_sync;
  logic [NC_SAMPLES-1:0] nc_shift;
  logic nc_out, cap_level, cap_prev;
  logic timer_clock_enable;
  logic cap_event;
  logic wr_cnt_l, wr_cnt_h, wr_cmp_a, wr_cmp_b, wr_flags;
  logic [15:0] counter_value;
  logic [15:0] next_count;
  logic ctc_mode, at_max, match_a8, match_b8, match16;

  // bus: writes commit in their one-cycle data phase, reads take one wait state
  // so the read mux always sees writes already committed
  wire accept = hsel && htrans[1] && hready;
  wire [7:0] ofs = req.addr;
  wire bus_wr = req.wr;
  wire [7:0] wdat = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
    end else if (accept) begin
      req.addr <= {haddr[7:2], 2'b00};
      req.wr <= hwrite;
      req.rd <= !hwrite;
    end else if (hreadyout) begin
      req <= '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (req.rd && !hreadyout) begin
      if (ofs == `TMR_OFS_CTRL_A) begin
        hrdata <= {23'h000000, ctrl};
      end else if (ofs == `TMR_OFS_CNT_L) begin
        hrdata <= {24'h000000, count_low_byte};
      end else if (ofs == `TMR_OFS_CNT_H) begin
        hrdata <= {24'h000000, count_high_byte};
      end else if (ofs == `TMR_OFS_CMP_A) begin
        hrdata <= {24'h000000, compare_reg_a};
      end else if (ofs == `TMR_OFS_CMP_B) begin
        hrdata <= {24'h000000, compare_reg_b};
      end else if (ofs == `TMR_OFS_MASK) begin
        hrdata <= {28'h0000000, timer_mask_register};
      end else if (ofs == `TMR_OFS_FLAGS) begin
        hrdata <= {28'h0000000, timer_flag_register};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  assign wr_cnt_l = bus_wr && ofs == `TMR_OFS_CNT_L;
  assign wr_cnt_h = bus_wr && ofs == `TMR_OFS_CNT_H;
  assign wr_cmp_a = bus_wr && ofs == `TMR_OFS_CMP_A;
  assign wr_cmp_b = bus_wr && ofs == `TMR_OFS_CMP_B;
  assign wr_flags = bus_wr && ofs == `TMR_OFS_FLAGS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `TMR_RST_CTRL;
      timer_mask_register <= `TMR_RST_FLAGS;
    end else if (bus_wr) begin
      if (ofs == `TMR_OFS_CTRL_A) begin
        ctrl <= hwdata[8:0];
      end else if (ofs == `TMR_OFS_MASK) begin
        timer_mask_register <= hwdata[3:0];
      end
    end
  end

  // clock source: free prescaler taps and synchronised external pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_count_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_comb begin
    case (ctrl.clk_sel)
      `TMR_CS_STOP: timer_clock_enable = 1'b0;
      `TMR_CS_DIV1: timer_clock_enable = 1'b1;
      `TMR_CS_DIV8: timer_clock_enable = &pre_cnt[2:0];
      `TMR_CS_DIV64: timer_clock_enable = &pre_cnt[5:0];
      `TMR_CS_DIV256: timer_clock_enable = &pre_cnt[7:0];
      `TMR_CS_DIV1024: timer_clock_enable = &pre_cnt[9:0];
      `TMR_CS_EXT_FALL: timer_clock_enable = ext_prev && !ext_sync;
      default: timer_clock_enable = !ext_prev && ext_sync;
    endcase
  end

  // counter
  assign counter_value = {count_high_byte, count_low_byte};
  assign ctc_mode = ctrl.ctc && !ctrl.wide && !ctrl.cap_en;
  assign at_max = ctrl.wide ? &counter_value : (count_low_byte == `TMR_MAX8);
  assign match_a8 = count_low_byte == compare_reg_a;
  assign match_b8 = count_low_byte == compare_reg_b;
  assign match16 = counter_value == {compare_reg_b, compare_reg_a};

  always_comb begin
    next_count = counter_value;
    if (ctc_mode && match_a8) begin
      next_count = {count_high_byte, `TMR_BOTTOM};
    end else if (ctrl.wide) begin
      next_count = counter_value + 16'h0001;
    end else begin
      next_count = {count_high_byte, count_low_byte + 8'h01};
    end
  end

  // any counter write suppresses that cycle's count or clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte <= `TMR_RST_BYTE;
      count_high_byte <= `TMR_RST_BYTE;
    end else if (wr_cnt_l || wr_cnt_h) begin
      if (wr_cnt_l) begin
        count_low_byte <= wdat;
      end
      if (wr_cnt_h) begin
        count_high_byte <= wdat;
      end
    end else if (timer_clock_enable) begin
      count_low_byte <= next_count[7:0];
      count_high_byte <= next_count[15:8];
    end
  end

  // capture path: source select, sync, optional filter, edge detect
  wire cap_src = ctrl.cap_src_cmp ? comparator_out : capture_input_pin;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
    end else begin
      cap_meta <= cap_src;
      cap_sync <= cap_meta;
    end
  end

  // filter always samples so enabling it mid-stream starts from a settled view
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nc_shift <= '0;
      nc_out <= 1'b0;
    end else begin
      nc_shift <= {nc_shift[NC_SAMPLES-2:0], cap_sync};
      // live sample is the fourth vote, so the filter costs four cycles, not five
      if (nc_shift[NC_SAMPLES-2:0] == {(NC_SAMPLES-1){cap_sync}}) begin
        nc_out <= cap_sync;
      end
    end
  end

  assign cap_level = ctrl.noise_en ? nc_out : cap_sync;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_prev <= 1'b0;
    end else begin
      cap_prev <= cap_level;
    end
  end

  assign cap_event = ctrl.cap_en && (ctrl.edge_rise ? (cap_level && !cap_prev)
                                                    : (!cap_level && cap_prev));

  // capture overrides a same-cycle bus write to compare A, and to compare B in 16-bit mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_reg_a <= `TMR_RST_BYTE;
      compare_reg_b <= `TMR_RST_BYTE;
    end else begin
      if (cap_event) begin
        compare_reg_a <= count_low_byte;
      end else if (wr_cmp_a) begin
        compare_reg_a <= wdat;
      end
      if (cap_event && ctrl.wide) begin
        compare_reg_b <= count_high_byte;
      end else if (wr_cmp_b) begin
        compare_reg_b <= wdat;
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_comb begin
    flag_set = 4'h0;
    flag_set[`TMR_FLG_OVF] = timer_clock_enable && at_max && !wr_cnt_l && !wr_cnt_h;
    flag_set[`TMR_FLG_CMPA] = timer_clock_enable && !ctrl.cap_en
                              && (ctrl.wide ? match16 : match_a8);
    flag_set[`TMR_FLG_CMPB] = timer_clock_enable && !ctrl.wide && match_b8;
    flag_set[`TMR_FLG_CAP] = cap_event;
    flag_clr = irq_ack | (wr_flags ? wdat[3:0] : 4'h0);
    next_flags = flag_set | (timer_flag_register & ~flag_clr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_flag_register <= `TMR_RST_FLAGS;
      irq_req <= 4'h0;
    end else begin
      timer_flag_register <= next_flags;
      irq_req <= next_flags & timer_mask_register;
    end
  end

  // checks
  AST_WRITE_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cnt_l |=> count_low_byte == $past(wdat))
    else $error("counter write lost to count");
  AST_STOPPED: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl.clk_sel == 3'h0 && !wr_cnt_l && !wr_cnt_h) |=> $stable(counter_value))
    else $error("counter moved while stopped");
  AST_CAP_COPY: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_event |=> compare_reg_a == $past(count_low_byte))
    else $error("capture did not copy counter");
  AST_CAP_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_event |=> timer_flag_register[`TMR_FLG_CAP] && compare_reg_a == $past(count_low_byte))
    else $error("capture flag not set with copy");
  AST_OVF: assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_clock_enable && at_max && !wr_cnt_l && !wr_cnt_h && !ctc_mode)
      |=> timer_flag_register[0] && count_low_byte == 8'h00)
    else $error("overflow not flagged at wrap");
  AST_CTC_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctc_mode && match_a8 && timer_clock_enable && !wr_cnt_l && !wr_cnt_h)
      |=> count_low_byte == 8'h00)
    else $error("clear on match failed");
  AST_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(nc_out) |-> nc_shift == {NC_SAMPLES{nc_out}})
    else $error("filter changed without four equal samples");
  AST_ONE_CMP: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl.wide |=> !timer_flag_register[2] || $past(timer_flag_register[2]))
    else $error("compare B flagged in 16-bit mode");
  AST_W1C: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_flags && wdat[3] && !cap_event) |=> !timer_flag_register[3])
    else $error("capture flag not cleared by write one");

endmodule

// [test/tb.sv]
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cap_pin, cmp_out, ext_pin, rdy_s;
  logic [31:0] haddr, hwdata, hrdata, rd_s, v;
  logic [1:0] htrans;
  logic [3:0] irq_ack, irq_req;
  int failures, tests_run, n0, n1;
  int dv[5] = '{1, 8, 64, 256, 1024};

  tmr_timer tmr_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(cap_pin), .comparator_out(cmp_out),
    .external_count_pin(ext_pin), .irq_ack(irq_ack), .irq_req(irq_req));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // values as they stand just before the next rising edge
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic chkb(input logic b);
    chk({31'h0, b}, 32'h1);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    v = rd_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_irq(input int b, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (irq_req[b] !== 1'b1 && n < 60);
    chkb(n < 60);
  endtask

  task automatic ack(input logic [3:0] m);
    @(posedge hclk);
    irq_ack <= m;
    @(posedge hclk);
    irq_ack <= 4'h0;
  endtask

  // ctrl settles 10 cycles first so a source or edge switch cannot fake an event
  task automatic fire(input logic [8:0] c, input logic lvl, output int n);
    wr(`TMR_OFS_CTRL_A, {23'h0, c});
    cyc(10);
    wr(`TMR_OFS_FLAGS, 32'hF);
    if (c[8]) cmp_out <= lvl;
    else cap_pin <= lvl;
    wait_irq(3, n);
  endtask

  task automatic t_regs;
    for (int a = 0; a < 32; a += 4) begin
      rd(a[7:0]);
      chk(v, 32'h0);
      chk({31'h0, hresp}, 32'h0);
    end
    wr(`TMR_OFS_CMP_A, 32'hFFFFFFFF);
    rd(`TMR_OFS_CMP_A);
    chk(v, 32'hFF);
    wr(`TMR_OFS_CNT_L, 32'h42);
    cyc(20);
    rd(`TMR_OFS_CNT_L);
    chk(v, 32'h42);
    $display("registers done");
  endtask

  task automatic t_count;
    wr(`TMR_OFS_MASK, 32'h1);
    wr(`TMR_OFS_CNT_L, 32'hF0);
    wr(`TMR_OFS_CTRL_A, 32'h1);
    wait_irq(0, n0);
    wr(`TMR_OFS_CTRL_A, 32'h0);
    rd(`TMR_OFS_CNT_L);
    chkb(v < 32'h20);
    ack(4'h1);
    rd(`TMR_OFS_FLAGS);
    chk(v & 32'h1, 32'h0);
    wr(`TMR_OFS_MASK, 32'h0);
    wr(`TMR_OFS_CNT_L, 32'hFE);
    wr(`TMR_OFS_CTRL_A, 32'h1);
    cyc(10);
    chk({31'h0, irq_req[0]}, 32'h0);
    wr(`TMR_OFS_CTRL_A, 32'h0);
    rd(`TMR_OFS_FLAGS);
    chk(v & 32'h1, 32'h1);
    wr(`TMR_OFS_CMP_A, 32'h5);
    wr(`TMR_OFS_CNT_L, 32'h0);
    wr(`TMR_OFS_CTRL_A, 32'h9);
    repeat (8) begin
      rd(`TMR_OFS_CNT_L);
      chkb(v <= 32'h5);
    end
    wr(`TMR_OFS_CTRL_A, 32'h1);
    cyc(8);
    rd(`TMR_OFS_CNT_L);
    chkb(v > 32'h5);
    for (int c = 1; c < 6; c++) begin
      wr(`TMR_OFS_CTRL_A, 32'h0);
      wr(`TMR_OFS_CNT_L, 32'h0);
      wr(`TMR_OFS_CTRL_A, c);
      cyc(6 * dv[c - 1]);
      wr(`TMR_OFS_CTRL_A, 32'h0);
      rd(`TMR_OFS_CNT_L);
      chkb(v >= 32'h5 && v <= 32'hA);
    end
    for (int c = 6; c < 8; c++) begin
      wr(`TMR_OFS_CNT_L, 32'h0);
      wr(`TMR_OFS_CTRL_A, c);
      repeat (5) begin
        ext_pin <= 1'b1;
        cyc(4);
        ext_pin <= 1'b0;
        cyc(4);
      end
      rd(`TMR_OFS_CNT_L);
      chk(v, 32'h5);
    end
    $display("counting done");
  endtask

  task automatic t_wide;
    wr(`TMR_OFS_CTRL_A, 32'h40);
    wr(`TMR_OFS_CNT_H, 32'h12);
    wr(`TMR_OFS_CNT_L, 32'hFE);
    wr(`TMR_OFS_CTRL_A, 32'h41);
    wr(`TMR_OFS_CTRL_A, 32'h40);
    rd(`TMR_OFS_CNT_H);
    chk(v, 32'h13);
    wr(`TMR_OFS_CNT_L, 32'hFE);
    wr(`TMR_OFS_CTRL_A, 32'h1);
    wr(`TMR_OFS_CTRL_A, 32'h0);
    rd(`TMR_OFS_CNT_H);
    chk(v, 32'h13);
    wr(`TMR_OFS_CMP_A, 32'h10);
    wr(`TMR_OFS_CMP_B, 32'h13);
    wr(`TMR_OFS_CTRL_A, 32'h40);
    wr(`TMR_OFS_CNT_L, 32'h0);
    wr(`TMR_OFS_FLAGS, 32'hF);
    wr(`TMR_OFS_MASK, 32'h2);
    wr(`TMR_OFS_CTRL_A, 32'h41);
    wait_irq(1, n0);
    cyc(6);
    wr(`TMR_OFS_CTRL_A, 32'h40);
    rd(`TMR_OFS_FLAGS);
    chk(v & 32'h6, 32'h2);
    $display("wide mode done");
  endtask

  task automatic t_cap;
    wr(`TMR_OFS_MASK, 32'h8);
    wr(`TMR_OFS_CTRL_A, 32'h0);
    wr(`TMR_OFS_CNT_L, 32'h37);
    fire(9'h0A0, 1'b1, n0);
    rd(`TMR_OFS_CMP_A);
    chk(v, 32'h37);
    wr(`TMR_OFS_FLAGS, 32'h8);
    rd(`TMR_OFS_FLAGS);
    chk(v & 32'h8, 32'h0);
    wr(`TMR_OFS_CNT_L, 32'h55);
    fire(9'h080, 1'b0, n0);
    rd(`TMR_OFS_CMP_A);
    chk(v, 32'h55);
    ack(4'h8);
    rd(`TMR_OFS_FLAGS);
    chk(v & 32'h8, 32'h0);
    wr(`TMR_OFS_CTRL_A, 32'h40);
    wr(`TMR_OFS_CNT_H, 32'hAB);
    wr(`TMR_OFS_CNT_L, 32'hCD);
    fire(9'h0E0, 1'b1, n0);
    rd(`TMR_OFS_CMP_A);
    chk(v, 32'hCD);
    rd(`TMR_OFS_CMP_B);
    chk(v, 32'hAB);
    wr(`TMR_OFS_CNT_L, 32'h21);
    fire(9'h1A0, 1'b1, n0);
    rd(`TMR_OFS_CMP_A);
    chk(v, 32'h21);
    fire(9'h080, 1'b0, n0);
    fire(9'h0A0, 1'b1, n0);
    fire(9'h090, 1'b0, n1);
    fire(9'h0B0, 1'b1, n1);
    chk(32'(n1 - n0), 32'h4);
    wr(`TMR_OFS_CTRL_A, 32'h90);
    cyc(10);
    wr(`TMR_OFS_FLAGS, 32'hF);
    cap_pin <= 1'b0;
    cyc(3);
    cap_pin <= 1'b1;
    cyc(20);
    rd(`TMR_OFS_FLAGS);
    chk(v & 32'h8, 32'h0);
    $display("capture done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    results;
  end

  initial begin
    failures = 0;
    tests_run = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    ext_pin = 1'b0;
    irq_ack = 4'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_count;
    t_wide;
    t_cap;
    results;
  end
endmodule
